// [logic/fan_mon_pkg.sv]
package fan_mon_pkg;

  // register byte offsets
  localparam logic [7:0] CFG_OFS        = 8'h00;
  localparam logic [7:0] ID_DIV_OFS     = 8'h04;
  localparam logic [7:0] FAN_A_VAL_OFS  = 8'h08;
  localparam logic [7:0] FAN_B_VAL_OFS  = 8'h0C;
  localparam logic [7:0] FAN_A_LIM_OFS  = 8'h10;
  localparam logic [7:0] FAN_B_LIM_OFS  = 8'h14;
  localparam logic [7:0] STATUS_OFS     = 8'h18;
  localparam logic [7:0] MASK_OFS       = 8'h1C;
  localparam logic [7:0] INTR_CLR_OFS   = 8'h20;

  // field positions
  localparam int unsigned CFG_START_BIT    = 0;
  localparam int unsigned CFG_INT_EN_BIT   = 1;
  localparam int unsigned CFG_INT_CLR_BIT  = 3;
  localparam int unsigned CFG_INTR_RST_BIT = 6;
  localparam int unsigned ICLR_RST_BIT     = 7;
  localparam int unsigned DIV_A_LSB        = 4;
  localparam int unsigned DIV_B_LSB        = 6;
  localparam int unsigned STAT_FAN_A       = 0;
  localparam int unsigned STAT_FAN_B       = 1;
  localparam int unsigned STAT_INTR        = 2;

  // values after reset
  localparam logic [7:0] CFG_RESET   = 8'h08;
  localparam logic [1:0] DIV_RESET   = 2'h1;
  localparam logic [7:0] LIMIT_RESET = 8'hFF;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET  = 3'h0;

  // timing
  localparam int unsigned CLK_HZ            = 125000000;
  localparam int unsigned REF_HZ            = 22500;
  localparam int unsigned REF_DIV_CYCLES    = CLK_HZ / REF_HZ;
  localparam int unsigned INTR_PULSE_MS     = 20;
  localparam int unsigned INTR_PULSE_CYCLES = INTR_PULSE_MS * ((CLK_HZ + 999) / 1000);

  typedef enum {FAN_IDLE, FAN_ARM, FAN_COUNT} fan_state_t;

  typedef struct packed {
    logic       done;
    logic [7:0] count;
  } fan_result_t;

endpackage

// [logic/fan_period_counter.sv]
`timescale 1ns/100ps
module fan_period_counter (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // control
  input  wire logic                  run,
  input  wire logic                  ref_tick,
  input  wire logic [1:0]            div_sel,
  input  wire logic                  tach_level,
  // measurement
  output fan_mon_pkg::fan_result_t   result
);

  fan_mon_pkg::fan_state_t state_reg, state_next;
  logic       tach_prev_reg, tach_prev_next;
  logic       edge_seen_reg, edge_seen_next;
  logic [2:0] pre_reg, pre_next;
  logic [7:0] cnt_reg, cnt_next;
  fan_mon_pkg::fan_result_t res_reg, res_next;
  logic       rise;
  logic [3:0] div_val;
  logic [2:0] div_last;

  assign rise     = tach_level & ~tach_prev_reg;
  assign div_val  = 4'h1 << div_sel;
  assign div_last = 3'(div_val - 4'h1);
  assign result   = res_reg;

  always_comb begin
    state_next     = state_reg;
    tach_prev_next = tach_level;
    edge_seen_next = edge_seen_reg;
    pre_next       = pre_reg;
    cnt_next       = cnt_reg;
    res_next       = res_reg;
    res_next.done  = 1'b0;
    if (!run) begin
      state_next = fan_mon_pkg::FAN_IDLE;
    end else begin
      case (state_reg)
        fan_mon_pkg::FAN_IDLE: begin
          state_next = fan_mon_pkg::FAN_ARM;
        end
        fan_mon_pkg::FAN_ARM: begin
          if (rise) begin
            state_next     = fan_mon_pkg::FAN_COUNT;
            edge_seen_next = 1'b0;
            pre_next       = 3'h0;
            cnt_next       = 8'h00;
          end
        end
        fan_mon_pkg::FAN_COUNT: begin
          // reference ticks pass the prescaler before the period counter
          if (ref_tick) begin
            if (pre_reg >= div_last) begin
              pre_next = 3'h0;
              if (cnt_reg != 8'hFF) begin
                cnt_next = cnt_reg + 8'h01;
              end
            end else begin
              pre_next = pre_reg + 3'h1;
            end
          end
          if (rise) begin
            if (edge_seen_reg) begin
              // the closing edge opens the next measurement, so no period is lost
              res_next.done  = 1'b1;
              res_next.count = cnt_reg;
              edge_seen_next = 1'b0;
              pre_next       = 3'h0;
              cnt_next       = 8'h00;
            end else begin
              edge_seen_next = 1'b1;
            end
          end
        end
        default: begin
          state_next = fan_mon_pkg::FAN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= fan_mon_pkg::FAN_IDLE;
      tach_prev_reg <= 1'b0;
      edge_seen_reg <= 1'b0;
      pre_reg       <= 3'h0;
      cnt_reg       <= 8'h00;
      res_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      tach_prev_reg <= tach_prev_next;
      edge_seen_reg <= edge_seen_next;
      pre_reg       <= pre_next;
      cnt_reg       <= cnt_next;
      res_reg       <= res_next;
    end
  end

endmodule

// [logic/fan_monitor.sv]
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module fan_monitor #(
  parameter int unsigned REF_DIV_CYCLES    = fan_mon_pkg::REF_DIV_CYCLES,
  parameter int unsigned INTR_PULSE_CYCLES = fan_mon_pkg::INTR_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // fan tachometers
  input  wire logic        tach_in_a,
  input  wire logic        tach_in_b,
  // cpu id straps
  input  wire logic [3:0]  cpu_id_inputs,
  // chassis intrusion, open drain
  input  wire logic        intrusion_pin_i,
  output logic             intrusion_pin_o,
  output logic             intrusion_pin_oe,
  // interrupt
  output logic             int_n
);

  localparam int unsigned REF_W   = $clog2(REF_DIV_CYCLES + 1);
  localparam int unsigned PULSE_W = $clog2(INTR_PULSE_CYCLES + 1);
  localparam int unsigned NPIN    = 7;

  // pin synchronisers: tach a, tach b, intrusion, cpu id
  logic [NPIN-1:0] sync1_reg, sync2_reg, sync3_reg, lvl_reg, lvl_next;
  logic [NPIN-1:0] pins;

  assign pins = {cpu_id_inputs, intrusion_pin_i, tach_in_b, tach_in_a};

  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < NPIN; i++) begin
      // a change is taken only once the last two stages agree
      if (sync2_reg[i] == sync3_reg[i]) begin
        lvl_next[i] = sync3_reg[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      lvl_reg   <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg   <= lvl_next;
    end
  end

  // registers
  logic [7:0] cfg_reg, cfg_next;
  logic [1:0] div_a_reg, div_a_next;
  logic [1:0] div_b_reg, div_b_next;
  logic [7:0] val_a_reg, val_a_next;
  logic [7:0] val_b_reg, val_b_next;
  logic [7:0] lim_a_reg, lim_a_next;
  logic [7:0] lim_b_reg, lim_b_next;
  logic [2:0] status_reg, status_next;
  logic [2:0] mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        int_n_reg, int_n_next;

  logic        run;
  logic        setup, wr, rd_access;
  logic        hit;
  logic [31:0] rd_data;
  logic        pulse_start;

  fan_mon_pkg::fan_result_t res_a, res_b;

  // both fans and the rest of the loop share this one start condition
  assign run       = cfg_reg[fan_mon_pkg::CFG_START_BIT]
                   & ~cfg_reg[fan_mon_pkg::CFG_INT_CLR_BIT];
  assign setup     = psel & ~penable;
  assign wr        = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;

  // reference clock, gated by the monitoring loop
  logic [REF_W-1:0] ref_cnt_reg, ref_cnt_next;
  logic             ref_tick_reg, ref_tick_next;

  always_comb begin
    ref_cnt_next  = ref_cnt_reg;
    ref_tick_next = 1'b0;
    if (!run) begin
      ref_cnt_next = '0;
    end else if (ref_cnt_reg == REF_W'(REF_DIV_CYCLES - 1)) begin
      ref_cnt_next  = '0;
      ref_tick_next = 1'b1;
    end else begin
      ref_cnt_next = ref_cnt_reg + REF_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg  <= '0;
      ref_tick_reg <= 1'b0;
    end else begin
      ref_cnt_reg  <= ref_cnt_next;
      ref_tick_reg <= ref_tick_next;
    end
  end

  fan_period_counter u_fan_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (run),
    .ref_tick   (ref_tick_reg),
    .div_sel    (div_a_reg),
    .tach_level (lvl_reg[0]),
    .result     (res_a)
  );

  fan_period_counter u_fan_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (run),
    .ref_tick   (ref_tick_reg),
    .div_sel    (div_b_reg),
    .tach_level (lvl_reg[1]),
    .result     (res_b)
  );

  // read decode
  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    if (paddr == fan_mon_pkg::CFG_OFS) begin
      rd_data[7:0] = cfg_reg;
    end else if (paddr == fan_mon_pkg::ID_DIV_OFS) begin
      rd_data[7:0] = {div_b_reg, div_a_reg, lvl_reg[6:3]};
    end else if (paddr == fan_mon_pkg::FAN_A_VAL_OFS) begin
      rd_data[7:0] = val_a_reg;
    end else if (paddr == fan_mon_pkg::FAN_B_VAL_OFS) begin
      rd_data[7:0] = val_b_reg;
    end else if (paddr == fan_mon_pkg::FAN_A_LIM_OFS) begin
      rd_data[7:0] = lim_a_reg;
    end else if (paddr == fan_mon_pkg::FAN_B_LIM_OFS) begin
      rd_data[7:0] = lim_b_reg;
    end else if (paddr == fan_mon_pkg::STATUS_OFS) begin
      rd_data[2:0] = status_reg;
    end else if (paddr == fan_mon_pkg::MASK_OFS) begin
      rd_data[2:0] = mask_reg;
    end else if (paddr == fan_mon_pkg::INTR_CLR_OFS) begin
      rd_data = 32'h0000_0000;
    end else begin
      hit = 1'b0;
    end
  end

  assign pready      = 1'b1;
  assign pslverr     = psel & penable & ~hit;
  assign prdata      = prdata_reg;
  assign pulse_start = wr & ((paddr == fan_mon_pkg::CFG_OFS
                             & pwdata[fan_mon_pkg::CFG_INTR_RST_BIT])
                           | (paddr == fan_mon_pkg::INTR_CLR_OFS
                             & pwdata[fan_mon_pkg::ICLR_RST_BIT]));

  always_comb begin
    cfg_next    = cfg_reg;
    div_a_next  = div_a_reg;
    div_b_next  = div_b_reg;
    val_a_next  = val_a_reg;
    val_b_next  = val_b_reg;
    lim_a_next  = lim_a_reg;
    lim_b_next  = lim_b_reg;
    status_next = status_reg;
    mask_next   = mask_reg;
    prdata_next = prdata_reg;
    // read data is caught in the setup cycle so it comes from a flop
    if (setup) begin
      prdata_next = pwrite ? 32'h0000_0000 : rd_data;
    end
    if (wr) begin
      if (paddr == fan_mon_pkg::CFG_OFS) begin
        // bit 6 is a strobe and is never stored
        cfg_next = 8'h00;
        cfg_next[fan_mon_pkg::CFG_START_BIT]   = pwdata[fan_mon_pkg::CFG_START_BIT];
        cfg_next[fan_mon_pkg::CFG_INT_EN_BIT]  = pwdata[fan_mon_pkg::CFG_INT_EN_BIT];
        cfg_next[fan_mon_pkg::CFG_INT_CLR_BIT] = pwdata[fan_mon_pkg::CFG_INT_CLR_BIT];
      end else if (paddr == fan_mon_pkg::ID_DIV_OFS) begin
        div_a_next = pwdata[fan_mon_pkg::DIV_A_LSB +: 2];
        div_b_next = pwdata[fan_mon_pkg::DIV_B_LSB +: 2];
      end else if (paddr == fan_mon_pkg::FAN_A_LIM_OFS) begin
        lim_a_next = pwdata[7:0];
      end else if (paddr == fan_mon_pkg::FAN_B_LIM_OFS) begin
        lim_b_next = pwdata[7:0];
      end else if (paddr == fan_mon_pkg::MASK_OFS) begin
        mask_next = pwdata[2:0];
      end
    end
    // only the bits the reader actually saw are cleared
    if (rd_access && paddr == fan_mon_pkg::STATUS_OFS) begin
      status_next = status_reg & ~prdata_reg[2:0];
    end
    // hardware updates land after the clear, so a coincident event wins
    if (res_a.done) begin
      val_a_next                          = res_a.count;
      status_next[fan_mon_pkg::STAT_FAN_A] = res_a.count > lim_a_reg;
    end
    if (res_b.done) begin
      val_b_next                          = res_b.count;
      status_next[fan_mon_pkg::STAT_FAN_B] = res_b.count > lim_b_reg;
    end
    if (lvl_reg[2]) begin
      status_next[fan_mon_pkg::STAT_INTR] = 1'b1;
    end
  end

  // interrupt pin: masked status ored, gated by enable and clear
  always_comb begin
    int_n_next = ~(cfg_reg[fan_mon_pkg::CFG_INT_EN_BIT]
                 & ~cfg_reg[fan_mon_pkg::CFG_INT_CLR_BIT]
                 & |(status_reg & ~mask_reg));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg    <= fan_mon_pkg::CFG_RESET;
      div_a_reg  <= fan_mon_pkg::DIV_RESET;
      div_b_reg  <= fan_mon_pkg::DIV_RESET;
      val_a_reg  <= fan_mon_pkg::VALUE_RESET;
      val_b_reg  <= fan_mon_pkg::VALUE_RESET;
      lim_a_reg  <= fan_mon_pkg::LIMIT_RESET;
      lim_b_reg  <= fan_mon_pkg::LIMIT_RESET;
      status_reg <= 3'h0;
      mask_reg   <= fan_mon_pkg::MASK_RESET;
      prdata_reg <= 32'h0000_0000;
      int_n_reg  <= 1'b1;
    end else begin
      cfg_reg    <= cfg_next;
      div_a_reg  <= div_a_next;
      div_b_reg  <= div_b_next;
      val_a_reg  <= val_a_next;
      val_b_reg  <= val_b_next;
      lim_a_reg  <= lim_a_next;
      lim_b_reg  <= lim_b_next;
      status_reg <= status_next;
      mask_reg   <= mask_next;
      prdata_reg <= prdata_next;
      int_n_reg  <= int_n_next;
    end
  end

  assign int_n = int_n_reg;

  // intrusion latch reset pulse; a new request restarts the full width
  logic [PULSE_W-1:0] pulse_cnt_reg, pulse_cnt_next;

  always_comb begin
    pulse_cnt_next = pulse_cnt_reg;
    if (pulse_start) begin
      pulse_cnt_next = PULSE_W'(INTR_PULSE_CYCLES);
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_next = pulse_cnt_reg - PULSE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_reg <= '0;
    end else begin
      pulse_cnt_reg <= pulse_cnt_next;
    end
  end

  assign intrusion_pin_o  = 1'b0;
  assign intrusion_pin_oe = pulse_cnt_reg != '0;

endmodule

// [test/fan_monitor_properties.sv]
`timescale 1ns/100ps
module fan_monitor_properties #(
  parameter int unsigned INTR_PULSE_CYCLES = 20
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // pins
  input wire logic        intrusion_pin_i,
  input wire logic        intrusion_pin_oe,
  input wire logic        int_n
);
  // mirrors of stored config {clear, enable, start}, mask and divisors
  logic [2:0]  cfg_reg;
  logic [2:0]  mask_reg;
  logic [3:0]  div_reg;
  logic [3:0]  hi_reg;
  int unsigned oe_reg;
  logic        wr_acc;
  logic        trig;

  assign wr_acc = psel && penable && pwrite;
  assign trig   = wr_acc && ((paddr == fan_mon_pkg::CFG_OFS && pwdata[6])
                  || (paddr == fan_mon_pkg::INTR_CLR_OFS && pwdata[7]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg  <= 3'h4;
      mask_reg <= 3'h0;
      div_reg  <= 4'h5;
      hi_reg   <= 4'h0;
      oe_reg   <= 0;
    end else begin
      if (wr_acc && paddr == fan_mon_pkg::CFG_OFS) begin
        cfg_reg <= {pwdata[3], pwdata[1:0]};
      end
      if (wr_acc && paddr == fan_mon_pkg::MASK_OFS) begin
        mask_reg <= pwdata[2:0];
      end
      if (wr_acc && paddr == fan_mon_pkg::ID_DIV_OFS) begin
        div_reg <= pwdata[7:4];
      end
      // pin high long enough to pass the synchroniser
      hi_reg <= !intrusion_pin_i ? 4'h0 : (hi_reg == 4'hF ? hi_reg : hi_reg + 4'h1);
      oe_reg <= trig ? INTR_PULSE_CYCLES : (oe_reg != 0 ? oe_reg - 1 : 0);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  AST_RD_CFG: assert property (s_rd(fan_mon_pkg::CFG_OFS) |=>
    prdata == {28'h0, cfg_reg[2], 1'b0, cfg_reg[1:0]}) else $error("config readback wrong");
  AST_RD_DIV: assert property (s_rd(fan_mon_pkg::ID_DIV_OFS) |=>
    prdata[7:4] == div_reg) else $error("divisor readback wrong");
  AST_INTR_RD: assert property (hi_reg >= 4'h8 ##0 s_rd(fan_mon_pkg::STATUS_OFS)
    |=> prdata[2]) else $error("intrusion status missing");
  AST_OE_WIN: assert property (intrusion_pin_oe == (oe_reg != 0))
    else $error("intrusion pull window wrong");
  AST_OE_CAUSE: assert property ($rose(intrusion_pin_oe) |-> $past(trig))
    else $error("intrusion pull without request");
  AST_INT_CLR: assert property (cfg_reg[2] [*2] |-> int_n)
    else $error("interrupt not released by clear bit");
  AST_INT_EN: assert property (!int_n |-> $past(cfg_reg[1]) && !$past(cfg_reg[2]))
    else $error("interrupt while disabled");
  AST_MASK_ALL: assert property ($past(mask_reg) == 3'h7 |-> int_n)
    else $error("interrupt with all sources masked");
endmodule

bind fan_monitor fan_monitor_properties #(.INTR_PULSE_CYCLES(INTR_PULSE_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .intrusion_pin_i(intrusion_pin_i),
  .intrusion_pin_oe(intrusion_pin_oe), .int_n(int_n)
);

// [test/fan_side_model.sv]
`timescale 1ns/100ps
module fan_side_model (
  // clock
  input  wire logic        pclk,
  // tach half periods in clocks, zero stops the fan
  input  wire logic [15:0] half_a,
  input  wire logic [15:0] half_b,
  // intrusion latch inputs, then the tach and pin outputs
  input  wire logic        intrude,
  input  wire logic        pull_low,
  output logic             tach_a,
  output logic             tach_b,
  output logic             pin_level
);
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic        latch;

  // the device's open-drain pull-down wins over the latch output
  assign pin_level = pull_low ? 1'b0 : latch;

  initial begin
    tach_a = 1'b0;
    tach_b = 1'b0;
    cnt_a  = 16'h0;
    cnt_b  = 16'h0;
    latch  = 1'b0;
  end

  always @(posedge pclk) begin
    cnt_a <= (half_a == 16'h0 || cnt_a + 16'h1 >= half_a) ? 16'h0 : cnt_a + 16'h1;
    cnt_b <= (half_b == 16'h0 || cnt_b + 16'h1 >= half_b) ? 16'h0 : cnt_b + 16'h1;
    if (half_a != 16'h0 && cnt_a + 16'h1 >= half_a) begin
      tach_a <= ~tach_a;
    end
    if (half_b != 16'h0 && cnt_b + 16'h1 >= half_b) begin
      tach_b <= ~tach_b;
    end
    if (pull_low) begin
      latch <= 1'b0;
    end else if (intrude) begin
      latch <= 1'b1;
    end
  end
endmodule

// [test/fan_monitor_tb.sv]
`timescale 1ns/100ps
module fan_monitor_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic        tach_a, tach_b, ci, ci_o, ci_oe, int_n, intrude;
  logic [15:0] half_a, half_b;
  int          fail_count;
  int          num_checks;
  logic [31:0] rst_exp [9] = '{32'h08, 32'h5A, 32'h00, 32'h00, 32'hFF, 32'hFF, 32'h00,
                               32'h00, 32'h00};

  fan_monitor #(.REF_DIV_CYCLES(4), .INTR_PULSE_CYCLES(20)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tach_in_a(tach_a), .tach_in_b(tach_b), .cpu_id_inputs(4'hA), .intrusion_pin_i(ci),
    .intrusion_pin_o(ci_o), .intrusion_pin_oe(ci_oe), .int_n(int_n));

  fan_side_model far_side (
    .pclk(pclk), .half_a(half_a), .half_b(half_b), .intrude(intrude), .pull_low(ci_oe),
    .tach_a(tach_a), .tach_b(tach_b), .pin_level(ci));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // entered just after a rising edge; leaves one idle edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count is assumed; only the watchdog ends a stuck access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // counts depend on reference phase, so one count either way is accepted
  task automatic near(input string nm, input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    num_checks++;
    if (((q + 1 >= e) && (q <= e + 1)) !== 1'b1) begin
      $display("Error %s expected %0d seen %h", nm, e, q);
      fail_count++;
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, intrude} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    half_a = 16'h0;
    half_b = 16'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      rd_chk("reset value", 8'(i * 4), rst_exp[i]);
    end
    rd_chk("unmapped read", 8'h24, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test registers done");

    half_a <= 16'd20;
    half_b <= 16'd32;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h08);
      apb(1'b1, fan_mon_pkg::ID_DIV_OFS, {24'h0, 2'(c), 2'(c), 4'h0});
      rd_chk("divisor", fan_mon_pkg::ID_DIV_OFS, {24'h0, 2'(c), 2'(c), 4'hA});
      apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h01);
      repeat (3 * (40 + 64) + 60) @(posedge pclk);
      near("fan a count", fan_mon_pkg::FAN_A_VAL_OFS, 80 / (4 << c));
      near("fan b count", fan_mon_pkg::FAN_B_VAL_OFS, 128 / (4 << c));
    end
    $display("test divisors done");

    apb(1'b1, fan_mon_pkg::FAN_A_LIM_OFS, 32'h00);
    apb(1'b1, fan_mon_pkg::FAN_B_LIM_OFS, 32'h0A);
    repeat (200) @(posedge pclk);
    rd_chk("fan status", fan_mon_pkg::STATUS_OFS, 32'h1);
    repeat (200) @(posedge pclk);
    chk("int_n disabled", 32'h1, {31'h0, int_n});
    apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h03);
    repeat (3) @(posedge pclk);
    chk("int_n active", 32'h0, {31'h0, int_n});
    apb(1'b1, fan_mon_pkg::MASK_OFS, 32'h01);
    repeat (3) @(posedge pclk);
    chk("int_n masked", 32'h1, {31'h0, int_n});
    apb(1'b1, fan_mon_pkg::MASK_OFS, 32'h07);
    repeat (3) @(posedge pclk);
    chk("int_n all masked", 32'h1, {31'h0, int_n});
    apb(1'b1, fan_mon_pkg::MASK_OFS, 32'h06);
    repeat (3) @(posedge pclk);
    chk("int_n other masks", 32'h0, {31'h0, int_n});
    apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h0B);
    repeat (3) @(posedge pclk);
    chk("int_n cleared", 32'h1, {31'h0, int_n});
    rd_chk("status kept", fan_mon_pkg::STATUS_OFS, 32'h1);
    rd_chk("status read clears", fan_mon_pkg::STATUS_OFS, 32'h0);
    apb(1'b0, fan_mon_pkg::FAN_A_VAL_OFS, 32'h0);
    v = q;
    half_a <= 16'd300;
    repeat (700) @(posedge pclk);
    rd_chk("value while halted", fan_mon_pkg::FAN_A_VAL_OFS, v);
    $display("test interrupt done");

    apb(1'b1, fan_mon_pkg::FAN_A_LIM_OFS, 32'hFF);
    apb(1'b1, fan_mon_pkg::ID_DIV_OFS, 32'h00);
    apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h01);
    repeat (3 * 600 + 100) @(posedge pclk);
    rd_chk("saturated count", fan_mon_pkg::FAN_A_VAL_OFS, 32'hFF);
    rd_chk("status at full scale", fan_mon_pkg::STATUS_OFS, 32'h2);
    $display("test saturation done");

    apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h08);
    apb(1'b0, fan_mon_pkg::STATUS_OFS, 32'h0);
    intrude <= 1'b1;
    @(posedge pclk);
    intrude <= 1'b0;
    repeat (10) @(posedge pclk);
    rd_chk("intrusion status", fan_mon_pkg::STATUS_OFS, 32'h4);
    rd_chk("intrusion held", fan_mon_pkg::STATUS_OFS, 32'h4);
    apb(1'b1, fan_mon_pkg::INTR_CLR_OFS, 32'h80);
    chk("pin pulled low", 32'h1, {31'h0, ci_oe});
    chk("open drain level", 32'h0, {31'h0, ci_o});
    repeat (25) @(posedge pclk);
    chk("pin released", 32'h0, {31'h0, ci_oe});
    rd_chk("clear bit self clears", fan_mon_pkg::INTR_CLR_OFS, 32'h0);
    apb(1'b0, fan_mon_pkg::STATUS_OFS, 32'h0);
    rd_chk("intrusion gone", fan_mon_pkg::STATUS_OFS, 32'h0);
    intrude <= 1'b1;
    @(posedge pclk);
    intrude <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, fan_mon_pkg::CFG_OFS, 32'h48);
    chk("pin pulled by config", 32'h1, {31'h0, ci_oe});
    rd_chk("config bit self clears", fan_mon_pkg::CFG_OFS, 32'h08);
    $display("test intrusion done");
    summarize();
  end
endmodule
